// ### logic/dac_front.sv
// audio DAC digital front end: clock ratio detect, init, audio port, control port
// assumes all pin inputs are asynchronous and sampled by CLOCK through two flops
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// [R1] detect clock ratio 128 to 768 automatically
// [R2] host: 128x modulator needs over 256x clock
// [R3] host: only listed ratios, not 512/768 at 192k
// [R4] run 1024-clock init then default registers
// [R5] host: reset pin low at least 20 ns
// [R6] reset pin rise restarts 1024-clock init
// [R7] shift audio data on bit clock rise
// [R8] host: word clock synchronous to system clock
// [R9] drift over 6 bit clocks mutes, resynchronises
// [R10] format field selects input format, default I2S
// [R11] samples are two's complement, msb first
// [R12] left-justified: high word clock means left
// [R13] I2S: low word clock means left
// [R14] filter bypass reuses audio pins, mono data
// [R15] stereo bypass takes left and right pins
// [R16] one-bit data sampled on its clock rise
// [R17] one-bit interface only when mode enabled
// [R18] host: grounds audio clocks in one-bit mode
// [R19] control port runs on its own clock
// [R20] control word: rw, 7-bit index, data byte
// [R21] host: select low, sixteen clocks per word
// [R22] read data driven after eighth clock
// [R23] write latched after sixteenth clock
// [R24] host: select high between words
// [R25] msb first on rise; aborted words discarded
module dac_front
  import dac_pkg::*;
(
  // clock and reset
  input  wire  logic                     CLOCK,
  input  wire  logic                     RSTN,
  input  wire  logic                     HARD_RESET_N,
  // avalon-mm register slave
  input  wire  logic [7:0]               ADDRESS,
  input  wire  logic                     READ,
  input  wire  logic                     WRITE,
  input  wire  logic [31:0]              WRITEDATA,
  input  wire  logic [3:0]               BYTEENABLE,
  output var   logic [31:0]              READDATA,
  output var   logic                     WAITREQUEST,
  // audio pins
  input  wire  dac_pkg::dac_audio_pins_s AUDIO_PINS,
  // control port pins
  input  wire  logic                     CTRL_BIT_CLOCK,
  input  wire  logic                     CTRL_SELECT_N,
  input  wire  logic                     CTRL_SERIAL_IN,
  output var   logic                     CTRL_SERIAL_OUT,
  output var   logic                     CTRL_SERIAL_OE_N,
  // samples towards the modulators
  output var   dac_pkg::dac_sample_s     SAMPLE,
  output var   logic                     SAMPLE_VALID,
  output var   logic [1:0]               ONEBIT_BITS,
  output var   logic                     ONEBIT_VALID,
  output var   logic                     INIT_BUSY
);
  import dac_pkg::*;

  // ****************************************
  // state
  // ****************************************
  localparam int PIN_LRCK = 0;
  localparam int PIN_BCK  = 1;
  localparam int PIN_DATA = 2;
  localparam int PIN_OBL  = 3;
  localparam int PIN_OBR  = 4;
  localparam int PIN_OBCK = 5;
  localparam int PIN_MC   = 6;
  localparam int PIN_MS   = 7;
  localparam int PIN_MDI  = 8;
  localparam int PIN_HRST = 9;

  typedef struct packed {
    logic [9:0]                    s1;         // first sync stage, read by s2 only
    logic [9:0]                    s2;         // synchronised pin levels
    logic [9:0]                    s3;         // previous levels for edge finding
    logic                          init_busy;  // initialisation running
    logic [10:0]                   init_cnt;   // clocks spent in initialisation
    logic [REG_COUNT-1:0][7:0]     mreg;       // mode registers 16..21
    logic                          wait_q;     // bus waitrequest
    logic [31:0]                   rdata;      // bus read data
    logic [11:0]                   frame_cnt;  // clocks since word clock rise
    logic [11:0]                   frame_len;  // last measured frame length
    logic [7:0]                    bck_cnt;    // clocks since bit clock rise
    logic [7:0]                    bck_len;    // last bit clock period
    dac_ratio_e                    ratio;      // detected clock ratio
    logic                          sync_lost;  // outputs held at bipolar zero
    logic [31:0]                   sr_l;       // audio data shift register, left in stereo bypass
    logic [31:0]                   sr_r;       // right shift register, stereo bypass
    logic [5:0]                    bitn;       // bits since word boundary
    dac_sample_s                   samp;       // latest sample pair
    logic                          samp_stb;   // new sample pulse
    logic [1:0]                    ob_bits;    // one-bit stream pair
    logic                          ob_stb;     // one-bit sample pulse
    dac_ctrl_e                     cstate;     // control port phase
    logic [15:0]                   csr;        // control word shift register
    logic [4:0]                    ccnt;       // control clocks seen
    logic                          crd;        // word is a read
    logic [7:0]                    rsh;        // read data shift register
    logic                          cout;       // serial out level
    logic                          coe_n;      // serial out enable, low drives
  } dac_state_s;

  localparam dac_state_s Q_RESET = '{
    init_busy: 1'b1, mreg: MREG_RESET, wait_q: 1'b1, ratio: RATIO_NONE,
    cstate: CP_IDLE, coe_n: 1'b1, default: '0};

  dac_state_s q;       // registered state
  dac_state_s d;       // next state

  // ****************************************
  // decode helpers
  // ****************************************
  // sign extend a right-justified word of the selected length
  function automatic logic [23:0] rj_word(input logic [31:0] sr, input logic [2:0] fmt);
    case (fmt)
      FMT_RJ16: rj_word = {{8{sr[15]}}, sr[15:0]};   // [R11]
      FMT_RJ20: rj_word = {{4{sr[19]}}, sr[19:0]};   // [R11]
      default:  rj_word = sr[23:0];
    endcase
  endfunction : rj_word

  // mode register by 7-bit index, zero outside the map
  function automatic logic [7:0] mode_reg(input logic [REG_COUNT-1:0][7:0] m,
                                          input logic [6:0] idx);
    logic [6:0] off;
    off = idx - REG_FIRST;
    if (idx >= REG_FIRST && off < 7'(REG_COUNT))
      mode_reg = m[off[2:0]];
    else
      mode_reg = 8'h00;
  endfunction : mode_reg

  // nearest supported ratio from clocks per frame
  function automatic dac_ratio_e classify(input logic [11:0] len);
    if (len < RLIM_LOW || len > RLIM_768) classify = RATIO_NONE;
    else if (len < RLIM_128)              classify = RATIO_128;
    else if (len < RLIM_192)              classify = RATIO_192;
    else if (len < RLIM_256)              classify = RATIO_256;
    else if (len < RLIM_384)              classify = RATIO_384;
    else if (len < RLIM_512)              classify = RATIO_512;
    else                                  classify = RATIO_768;
  endfunction : classify

  logic [9:0]  rise;         // synchronised rising edges
  logic [9:0]  fall;         // synchronised falling edges
  logic [2:0]  fmt;          // active input format
  logic        bypass;       // external filter mode
  logic        stereo;       // stereo external filter data
  logic        onebit_en;    // one-bit stream mode
  logic [11:0] period;       // frame just measured
  logic [11:0] drift;        // distance from previous frame
  logic        drift_big;    // drift beyond tolerance
  logic        pcm_on;       // audio shifter runs
  logic        bus_commit;   // bus write lands this edge
  logic        ctrl_commit;  // control port write lands this edge
  logic [6:0]  bus_idx;      // bus word index widened to a register index

  assign rise      = q.s2 & ~q.s3;
  assign fall      = ~q.s2 & q.s3;
  assign fmt       = q.mreg[REG_FMT - REG_FIRST][FMT_LSB +: 3];           // [R10]
  assign bypass    = q.mreg[REG_MODE - REG_FIRST][BYPASS_BIT];
  assign stereo    = q.mreg[REG_STEREO - REG_FIRST][STEREO_BIT];
  assign onebit_en = q.mreg[REG_MODE - REG_FIRST][ONEBIT_BIT];
  assign period    = (q.frame_cnt == CNT_MAX) ? CNT_MAX : q.frame_cnt + 12'h001;
  assign drift     = (period > q.frame_len) ? period - q.frame_len : q.frame_len - period;
  assign drift_big = drift > 12'(DRIFT_BCK * {4'h0, q.bck_len});          // [R9]
  assign pcm_on    = !q.init_busy && !onebit_en;
  assign bus_idx   = {1'b0, ADDRESS[7:2]};
  assign bus_commit = WRITE && !q.wait_q && BYTEENABLE[0] && !q.init_busy;
  // the sixteenth rise completes the word; aborted words never reach here
  assign ctrl_commit = !q.init_busy && !q.s2[PIN_MS] && q.cstate == CP_SHIFT
                       && rise[PIN_MC] && q.ccnt == CTRL_BITS - 5'h01
                       && !q.csr[14];                                      // [R23] [R25]

  // ****************************************
  // next-state logic
  // ****************************************
  // one pass computes every field; later assignments override earlier ones
  always_comb
  begin
    d          = q;
    d.samp_stb = 1'b0;
    d.ob_stb   = 1'b0;
    // two-stage synchronisers on every pin, the control port included
    d.s1 = {HARD_RESET_N, CTRL_SERIAL_IN, CTRL_SELECT_N, CTRL_BIT_CLOCK,
            AUDIO_PINS.onebit_bit_clock, AUDIO_PINS.onebit_right_in,
            AUDIO_PINS.onebit_left_in, AUDIO_PINS.pcm_serial_in,
            AUDIO_PINS.pcm_bit_clock, AUDIO_PINS.lr_word_clock};          // [R19]
    d.s2 = q.s1;
    d.s3 = q.s2;

    // initialisation: held while the pin is low, restarted on its release
    if (!q.s2[PIN_HRST])
    begin
      d.init_busy = 1'b1;                                                 // [R5] [R6]
      d.init_cnt  = '0;
    end
    else if (q.init_busy)
    begin
      if (q.init_cnt == INIT_CYCLES - 11'h001)
        d.init_busy = 1'b0;                                               // [R4]
      else
        d.init_cnt = q.init_cnt + 11'h001;                                // [R4] [R6]
    end

    // bus slave: one wait cycle, then the answer
    d.wait_q = 1'b1;
    if ((READ || WRITE) && q.wait_q)
    begin
      d.wait_q = 1'b0;
      case (ADDRESS[7:2])
        IDX_STATUS: d.rdata = {4'h0, q.frame_len, 10'h000, q.init_busy,
                               q.sync_lost, 1'b0, q.ratio};               // [R1]
        IDX_LEFT:   d.rdata = {{8{q.samp.left[23]}}, q.samp.left};
        IDX_RIGHT:  d.rdata = {{8{q.samp.right[23]}}, q.samp.right};
        default:    d.rdata = {24'h000000, mode_reg(q.mreg, bus_idx)};
      endcase
    end
    if (bus_commit && mode_reg(q.mreg, bus_idx) == mode_reg(q.mreg, bus_idx)
        && bus_idx >= REG_FIRST && bus_idx < REG_FIRST + 7'(REG_COUNT))
      d.mreg[3'(bus_idx - REG_FIRST)] = WRITEDATA[7:0];

    // clock ratio and drift, measured on the word clock
    d.frame_cnt = (q.frame_cnt == CNT_MAX) ? CNT_MAX : q.frame_cnt + 12'h001;
    d.bck_cnt   = (q.bck_cnt == 8'hff) ? 8'hff : q.bck_cnt + 8'h01;
    if (rise[PIN_BCK])
    begin
      d.bck_len = q.bck_cnt + 8'h01;
      d.bck_cnt = '0;
    end
    if (rise[PIN_LRCK])
    begin
      d.frame_cnt = '0;
      d.frame_len = period;
      d.ratio     = classify(period);                                     // [R1]
    end

    // audio port: shift, capture on word boundaries or bit counts
    if (pcm_on)
    begin
      if (rise[PIN_LRCK] || fall[PIN_LRCK])
      begin
        d.bitn = '0;
        if (bypass)
        begin
          d.samp.left  = q.sr_l[23:0];                                    // [R14]
          d.samp.right = stereo ? q.sr_r[23:0] : q.sr_l[23:0];            // [R15]
          d.samp_stb   = 1'b1;
        end
        else if (fmt == FMT_RJ16 || fmt == FMT_RJ20 || fmt == FMT_RJ24)
        begin
          // word clock was high for the word just ended: left
          if (q.s3[PIN_LRCK])
            d.samp.left = rj_word(q.sr_l, fmt);
          else
            d.samp.right = rj_word(q.sr_l, fmt);
          d.samp_stb = 1'b1;
        end
      end
      if (rise[PIN_BCK])
      begin
        // msb arrives first, so older bits climb towards the top
        d.sr_l = {q.sr_l[30:0], (bypass && stereo) ? q.s2[PIN_OBL] : q.s2[PIN_DATA]}; // [R7]
        d.sr_r = {q.sr_r[30:0], q.s2[PIN_OBR]};                           // [R15]
        d.bitn = (d.bitn == 6'h3f) ? d.bitn : d.bitn + 6'h01;
        if (!bypass && ((fmt == FMT_LJ24 && d.bitn == LJ_BITS) ||
                        (fmt >= FMT_I2S24 && d.bitn == I2S_BITS)))
        begin
          if (q.s2[PIN_LRCK] == (fmt == FMT_LJ24))
            d.samp.left = d.sr_l[23:0];                                   // [R12] [R13]
          else
            d.samp.right = d.sr_l[23:0];                                  // [R12] [R13]
          d.samp_stb = 1'b1;
        end
      end
      // a frame that moved too far restarts the shifter at once
      if (rise[PIN_LRCK])
      begin
        if (drift_big)
        begin
          d.sync_lost = 1'b1;                                             // [R8] [R9]
          d.bitn      = '0;
          d.sr_l      = '0;
          d.sr_r      = '0;
        end
        else
          d.sync_lost = 1'b0;                                             // [R9]
      end
    end
    else
      d.sync_lost = 1'b0;

    // one-bit stream: only while its mode is on
    if (onebit_en && !q.init_busy && rise[PIN_OBCK])
    begin
      d.ob_bits = {q.s2[PIN_OBL], q.s2[PIN_OBR]};                         // [R16] [R17]
      d.ob_stb  = 1'b1;
    end

    // control port: select high ends any word, finished or not
    if (q.s2[PIN_MS] || q.init_busy)
    begin
      d.cstate = CP_IDLE;                                                 // [R25]
      d.ccnt   = '0;
      d.coe_n  = 1'b1;
    end
    else if (q.cstate != CP_DONE)
    begin
      d.cstate = CP_SHIFT;
      if (rise[PIN_MC])
      begin
        d.csr  = {q.csr[14:0], q.s2[PIN_MDI]};                            // [R20] [R25]
        d.ccnt = q.ccnt + 5'h01;
        if (d.ccnt == CTRL_READ_AT)
        begin
          d.crd = d.csr[7];                                               // [R20]
          d.rsh = mode_reg(q.mreg, d.csr[6:0]);                           // [R22]
        end
        if (d.ccnt == CTRL_BITS)
          d.cstate = CP_DONE;                                             // [R24]
      end
      if (fall[PIN_MC] && q.crd && q.ccnt >= CTRL_READ_AT)
      begin
        d.cout  = q.rsh[7];                                               // [R22]
        d.rsh   = {q.rsh[6:0], 1'b0};
        d.coe_n = 1'b0;
      end
    end
    // only indices inside the map may land; others would index past the array
    if (ctrl_commit && q.csr[13:7] >= REG_FIRST
        && q.csr[13:7] < REG_FIRST + 7'(REG_COUNT))
      // last data bit is still on the pin at the sixteenth rise
      d.mreg[3'(q.csr[13:7] - REG_FIRST)] = {q.csr[6:0], q.s2[PIN_MDI]}; // [R23]
    // control port applied after the bus, so it wins a same-cycle clash

    // defaults during initialisation; bipolar zero while unsynchronised
    if (q.init_busy)
      d.mreg = MREG_RESET;                                                // [R4]
    if (d.sync_lost || d.init_busy)
    begin
      d.samp     = '0;                                                    // [R9]
      d.samp_stb = 1'b0;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
      q <= Q_RESET;
    else
      q <= d;
  end

  assign READDATA         = q.rdata;
  assign WAITREQUEST      = q.wait_q;
  assign CTRL_SERIAL_OUT  = q.cout;
  assign CTRL_SERIAL_OE_N = q.coe_n;
  assign SAMPLE           = q.samp;
  assign SAMPLE_VALID     = q.samp_stb;
  assign ONEBIT_BITS      = q.ob_bits;
  assign ONEBIT_VALID     = q.ob_stb;
  assign INIT_BUSY        = q.init_busy;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);

  init_len_a: assert property ($fell(q.init_busy) |-> $past(q.init_cnt) == INIT_CYCLES - 11'h001) // [R4]
    else $error("initialisation length wrong");
  hard_rst_a: assert property (!q.s2[PIN_HRST] |=> q.init_busy && q.init_cnt == 11'h000) // [R6]
    else $error("reset pin did not restart initialisation");
  fmt_def_a: assert property ($fell(q.init_busy) |-> fmt == FMT_I2S24) // [R10]
    else $error("format default wrong after initialisation");
  ratio_det_a: assert property (rise[PIN_LRCK] && q.frame_cnt == 12'h0ff |=> q.ratio == RATIO_256) // [R1]
    else $error("ratio 256 not detected");
  mute_zero_a: assert property (q.sync_lost |-> q.samp == '0 && !q.samp_stb) // [R9]
    else $error("outputs not at bipolar zero");
  drift_reinit_a: assert property (pcm_on && rise[PIN_LRCK] && drift_big
                                   |=> q.sync_lost && q.bitn == 6'h00) // [R9]
    else $error("drift did not reinitialise");
  pcm_shift_a: assert property (pcm_on && !bypass && rise[PIN_BCK]
                                && !(rise[PIN_LRCK] && drift_big)
                                |=> q.sr_l[0] == $past(q.s2[PIN_DATA])) // [R7]
    else $error("audio bit not shifted in");
  onebit_gate_a: assert property (q.ob_stb |-> $past(onebit_en) && $past(rise[PIN_OBCK])) // [R16]
    else $error("one-bit sample without mode or clock");
  ctrl_oe_a: assert property (!q.coe_n |-> q.crd && q.ccnt >= CTRL_READ_AT) // [R22]
    else $error("serial out driven outside read data phase");
  reg_change_a: assert property (q.mreg != $past(q.mreg) && !$past(q.init_busy)
                                 |-> $past(bus_commit) || $past(ctrl_commit)) // [R23]
    else $error("mode register changed without a write");

  sample_c: cover property (q.samp_stb && !bypass);
  ctrl_wr_c: cover property (ctrl_commit);
  sync_lost_c: cover property ($rose(q.sync_lost));
  onebit_c: cover property (q.ob_stb);

endmodule : dac_front
`default_nettype wire

// ### logic/dac_pkg.sv
// constants, types and register layout for the audio DAC front end
// assumes a single 50 MHz system clock; all pin inputs are asynchronous
package dac_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int          CLK_HZ         = 50_000_000;   // system clock rate
  localparam int          HRST_MIN_NS    = 20;           // least low time on the reset pin
  localparam int          HRST_MIN_CYC   = (HRST_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [10:0] INIT_CYCLES    = 11'h400;      // initialisation length, 1024 clocks
  localparam logic [11:0] DRIFT_BCK      = 12'h006;      // allowed frame drift in bit clocks
  localparam logic [11:0] CNT_MAX        = 12'hfff;      // saturation of the frame counter; the bit clock counter stops at 8'hff

  // ****************************************
  // ratio detection thresholds (clocks per frame)
  // ****************************************
  localparam logic [11:0] RLIM_LOW       = 12'h070;      // below: no supported ratio
  localparam logic [11:0] RLIM_128       = 12'h0a0;
  localparam logic [11:0] RLIM_192       = 12'h0e0;
  localparam logic [11:0] RLIM_256       = 12'h140;
  localparam logic [11:0] RLIM_384       = 12'h1c0;
  localparam logic [11:0] RLIM_512       = 12'h280;
  localparam logic [11:0] RLIM_768       = 12'h340;      // above: no supported ratio

  typedef enum logic [2:0] {
    RATIO_NONE, RATIO_128, RATIO_192, RATIO_256, RATIO_384, RATIO_512, RATIO_768
  } dac_ratio_e;

  // ****************************************
  // mode registers
  // ****************************************
  localparam logic [6:0]  REG_FIRST      = 7'h10;        // index of the first mode register
  localparam int          REG_COUNT      = 6;            // indices 16 to 21
  localparam logic [6:0]  REG_FMT        = 7'h12;        // format register
  localparam logic [6:0]  REG_STEREO     = 7'h13;        // stereo bypass register
  localparam logic [6:0]  REG_MODE       = 7'h14;        // bypass and one-bit mode register
  localparam int          FMT_LSB        = 0;            // format_select [2:0]
  localparam int          STEREO_BIT     = 5;            // stereo_bypass_select
  localparam int          BYPASS_BIT     = 2;            // filter_bypass
  localparam int          ONEBIT_BIT     = 5;            // onebit_mode_enable
  localparam logic [47:0] MREG_RESET     = 48'h00_00_00_04_ff_ff; // regs 21..16

  localparam logic [2:0]  FMT_RJ16       = 3'h0;
  localparam logic [2:0]  FMT_RJ20       = 3'h1;
  localparam logic [2:0]  FMT_RJ24       = 3'h2;
  localparam logic [2:0]  FMT_LJ24       = 3'h3;
  localparam logic [2:0]  FMT_I2S24      = 3'h4;
  localparam logic [5:0]  LJ_BITS        = 6'h18;        // left-justified capture point
  localparam logic [5:0]  I2S_BITS       = 6'h19;        // one bit later for the delayed format

  // ****************************************
  // bus word indices and status layout
  // ****************************************
  localparam logic [5:0]  IDX_STATUS     = 6'h30;
  localparam logic [5:0]  IDX_LEFT       = 6'h31;
  localparam logic [5:0]  IDX_RIGHT      = 6'h32;
  localparam logic [4:0]  CTRL_READ_AT   = 5'h08;        // read data follows this clock
  localparam logic [4:0]  CTRL_BITS      = 5'h10;        // length of a control word

  typedef enum logic [1:0] {CP_IDLE, CP_SHIFT, CP_DONE} dac_ctrl_e;

  typedef struct packed {
    logic lr_word_clock;
    logic pcm_bit_clock;
    logic pcm_serial_in;
    logic onebit_left_in;
    logic onebit_right_in;
    logic onebit_bit_clock;
  } dac_audio_pins_s;

  typedef struct packed {
    logic [23:0] left;
    logic [23:0] right;
  } dac_sample_s;

endpackage : dac_pkg

// ### bench/dac_host.sv
// host and audio source model: control words, I2S frames, one-bit bits
// assumes pins are plain levels; bit clocks stand still between calls
`timescale 1ns/1ns
`default_nettype none
module dac_host
  import dac_pkg::*;
(
  output var dac_pkg::dac_audio_pins_s pins,
  output var logic mc,
  output var logic ms_n,
  output var logic ctrl_serial_in,
  input  wire logic ctrl_serial_out
);
  logic [15:0] rd;  // bits seen on the serial out, sampled before each rise
  initial pins = '0;
  initial mc = 1'b0;
  initial ms_n = 1'b1;  // idle high
  initial ctrl_serial_in = 1'b0;
  // n clocks of one word, msb first; n below 16 aborts it
  task automatic word(input logic [15:0] w, input int n);
    ms_n = 1'b0;
    for (int i = 15; i > 15 - n; i--)
    begin
      ctrl_serial_in = w[i];
      #160 rd[i] = ctrl_serial_out;
      mc = 1'b1;
      #160 mc = 1'b0;
    end
    #160 ms_n = 1'b1;
    ctrl_serial_in = ~ctrl_serial_in;  // released line shows no stale value
    #400;
  endtask : word
  // one I2S frame, 32 bits a channel, low word clock is left
  // word clock timed from the same base as CLOCK, 512x ratio
  task automatic frame(input logic [23:0] l, input logic [23:0] r);
    int k;
    for (int b = 0; b < 64; b++)
    begin
      k = b % 32;
      pins.lr_word_clock = b >= 32;
      pins.pcm_serial_in = (k >= 1 && k <= 24) ? (b < 32 ? l[24 - k] : r[24 - k]) : k[0];
      #80 pins.pcm_bit_clock = 1'b1;
      #80 pins.pcm_bit_clock = 1'b0;
    end
  endtask : frame
  // one one-bit sample; audio clocks grounded meanwhile
  task automatic onebit(input logic l, input logic r);
    pins.lr_word_clock = 1'b0;
    pins.onebit_left_in = l;
    pins.onebit_right_in = r;
    #80 pins.onebit_bit_clock = 1'b1;
    #80 pins.onebit_bit_clock = 1'b0;
  endtask : onebit
endmodule : dac_host
`default_nettype wire

// ### bench/testbench.sv
// self-checking bench for the audio DAC front end
// assumes dac_front and dac_host; avalon master runs on CLOCK
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import dac_pkg::*;
  logic CLOCK = 0, RSTN = 0, HARD_RESET_N = 1, READ = 0, WRITE = 0;
  logic [7:0] ADDRESS = '0;
  logic [31:0] WRITEDATA = '0, READDATA, rdata;
  logic WAITREQUEST, mc, ms_n, ctrl_serial_in, ctrl_serial_out, sv, ov, busy, oe_n;
  dac_audio_pins_s pins;
  dac_sample_s smp;
  logic [1:0] ob;
  int fail_count = 0, n_checks = 0;
  always #10 CLOCK = ~CLOCK;
  dac_front i_dut (.CLOCK(CLOCK), .RSTN(RSTN), .HARD_RESET_N(HARD_RESET_N),
    .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA),
    .BYTEENABLE(4'h1), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
    .AUDIO_PINS(pins), .CTRL_BIT_CLOCK(mc), .CTRL_SELECT_N(ms_n),
    .CTRL_SERIAL_IN(ctrl_serial_in), .CTRL_SERIAL_OUT(ctrl_serial_out), .CTRL_SERIAL_OE_N(oe_n),
    .SAMPLE(smp), .SAMPLE_VALID(sv), .ONEBIT_BITS(ob), .ONEBIT_VALID(ov),
    .INIT_BUSY(busy));
  dac_host i_host (.pins(pins), .mc(mc), .ms_n(ms_n), .ctrl_serial_in(ctrl_serial_in), .ctrl_serial_out(ctrl_serial_out));
  // compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    ADDRESS <= a;
    WRITE <= w;
    READ <= !w;
    WRITEDATA <= d;
    do @(posedge CLOCK); while (WAITREQUEST !== 1'b0);
    rdata = READDATA;
    READ <= 1'b0;
    WRITE <= 1'b0;
    @(posedge CLOCK);
  endtask : bus
  task automatic t_init;
    chk("busy", 1, busy);
    repeat (1030) @(posedge CLOCK);
    chk("busy", 0, busy);
    bus(0, 8'h48, 0);
    chk("fmt", 32'h04, rdata);
    bus(0, 8'hfc, 0);
    chk("unmapped", 0, rdata);
  endtask : t_init
  task automatic t_ctrl;
    @(negedge CLOCK);
    i_host.word(16'h135a, 16);
    bus(0, 8'h4c, 0);
    chk("wr", 32'h5a, rdata);
    @(negedge CLOCK);
    i_host.word(16'h13a5, 12);
    bus(0, 8'h4c, 0);
    chk("abort", 32'h5a, rdata);
    @(negedge CLOCK);
    i_host.word(16'h9300, 16);
    chk("rd", 32'h5a, i_host.rd[7:0]);
    chk("oe_n", 1, oe_n);
  endtask : t_ctrl
  task automatic t_i2s;
    @(negedge CLOCK);
    repeat (4) i_host.frame(24'h8a5c31, 24'h13579b);
    repeat (8) @(posedge CLOCK);
    chk("left", 32'h8a5c31, smp.left);
    chk("right", 32'h13579b, smp.right);
    bus(0, 8'hc0, 0);
    chk("ratio", 32'h5, rdata & 32'h7);
  endtask : t_i2s
  task automatic t_onebit;
    @(negedge CLOCK);
    i_host.onebit(1, 0);
    chk("off", 0, ob);
    bus(1, 8'h50, 32'h20);
    @(negedge CLOCK);
    i_host.onebit(1, 0);
    repeat (4) @(posedge CLOCK);
    chk("bits", 32'h2, ob);
  endtask : t_onebit
  task automatic t_hrst;
    HARD_RESET_N <= 1'b0;
    repeat (4) @(posedge CLOCK);
    HARD_RESET_N <= 1'b1;
    repeat (4) @(posedge CLOCK);
    chk("hbusy", 1, busy);
    repeat (1030) @(posedge CLOCK);
    bus(0, 8'h4c, 0);
    chk("hreg", 0, rdata);
  endtask : t_hrst
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results
  // watchdog cuts a hang short
  initial
  begin
    #400000;
    fail_count++;
    results();
  end
  initial
  begin
    repeat (6) @(posedge CLOCK);
    RSTN <= 1'b1;
    @(posedge CLOCK);
    t_init();
    t_ctrl();
    t_i2s();
    t_onebit();
    t_hrst();
    results();
  end
endmodule : testbench
`default_nettype wire
